// file: design/swd_defines.svh
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH

// Clock rate in kHz (20 MHz)
`define SWD_CLK_KHZ 20000
// Kick pulse least width in ns, and cycles (rounded up, at least one)
`define SWD_KICK_MIN_NS 100
`define SWD_KICK_MIN_CYC ((`SWD_KICK_MIN_NS * `SWD_CLK_KHZ + 999999) / 1000000)
// Internal timeout 1.6 s, in ms
`define SWD_INT_TMO_MS 1600
// Capacitor timeout: 2.1 ms per nF, kept in tenths of ms per nF
`define SWD_CAP_TENTHS_MS_PER_NF 21
`define SWD_CAP_MIN_NF 8'h05
`define SWD_CAP_MAX_NF 8'h64
// Warning pulse 1 ms
`define SWD_WARN_MS 1
// Fault follows warning fall by 70 ns (rounded up)
`define SWD_FAULT_DLY_NS 70
`define SWD_FAULT_DLY_CYC ((`SWD_FAULT_DLY_NS * `SWD_CLK_KHZ + 999999) / 1000000)
// Chip-select hold after reset assertion 15 us (rounded down)
`define SWD_CS_HOLD_US 15
`define SWD_CS_HOLD_CYC ((`SWD_CS_HOLD_US * `SWD_CLK_KHZ) / 1000)
// Reset timeout 200 ms
`define SWD_RST_TMO_MS 200
// Manual reset least low time 15 us (rounded up)
`define SWD_MR_MIN_US 15
`define SWD_MR_MIN_CYC ((`SWD_MR_MIN_US * `SWD_CLK_KHZ + 999) / 1000)
// Cycles per millisecond
`define SWD_CYC_PER_MS `SWD_CLK_KHZ

`endif

// file: design/swd_pkg.sv
package swd_pkg;

	typedef enum logic [1:0] {
		SWD_WD_RUN = 2'b00,
		SWD_WD_WARN = 2'b01,
		SWD_WD_DLY = 2'b10,
		SWD_WD_FAULT = 2'b11
	} swd_wd_state_type;

	typedef enum logic [1:0] {
		SWD_CS_PASS = 2'b00,
		SWD_CS_HOLD = 2'b01,
		SWD_CS_OFF = 2'b10
	} swd_cs_state_type;

	// Analog comparator status, synchronous to the clock
	typedef struct packed {
		logic below_thresh;
		logic batt_backup;
		logic kick_open;
	} swd_status_type;

	// Watchdog outputs, both active low
	typedef struct packed {
		logic warn_n;
		logic fault_n;
	} swd_wd_out_type;

endpackage : swd_pkg

// file: design/swd_supervisor.sv
// What this block does
// - Any kick level change or 100ns pulse restarts the timeout.
// - Timeout select tied to supply uses internal 1.6 s timeout.
// - Capacitor timeout is 2.1 ms per nF, 5nF to 100nF.
// - Open mid-level kick input disables watchdog, no faults.
// - Below reset threshold the watchdog is off and kick ignored.
// - Fault output high when below threshold, on battery, or open kick.
// - Missed timeout drives warning pulse low for 1 ms.
// - Fault falls 70 ns after warning falls; high when a first miss makes warning fall, already low on a repeat miss.
// - Fault stays low until the next kick level change; after a kick during the warning pulse it rises when the pulse ends.
// - Reset inactive: chip-select output follows chip-select input.
// - Reset asserted: chip-select path open, memory not selected.
// - Disabled gate drives chip-select output high; released on enable.
// - Power-down: disconnect on input high or 15 us after reset.
// - Power-up: path stays off until reset deasserts after timeout.
// - Reset holds 200 ms after threshold rise or manual reset release.
// - Manual reset low 15 us clears counters, watchdog outputs high, reset output low, gate off.
`timescale 1ns/10ps
`include "swd_defines.svh"

module swd_supervisor #(
	parameter int TMO_W = 32,
	parameter int CNT_W = 24,
	parameter logic [TMO_W-1:0] INT_TMO_CYC =
		TMO_W'(`SWD_INT_TMO_MS * `SWD_CYC_PER_MS),
	parameter logic [CNT_W-1:0] WARN_CYC =
		CNT_W'(`SWD_WARN_MS * `SWD_CYC_PER_MS),
	parameter logic [CNT_W-1:0] RST_TMO_CYC =
		CNT_W'(`SWD_RST_TMO_MS * `SWD_CYC_PER_MS),
	parameter logic [CNT_W-1:0] CYC_PER_MS = CNT_W'(`SWD_CYC_PER_MS)
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic watchdog_kick_in,
	input wire swd_pkg::swd_status_type status_in,
	input wire logic timeout_select_pin,
	input wire logic [7:0] cap_nf_in,
	input wire logic manual_reset_in_n,
	input wire logic cs_in_n,
	output logic reset_out_n,
	output swd_pkg::swd_wd_out_type wd_out,
	output logic cs_out_n,
	output logic cs_out_oe
);

	localparam int KMIN = `SWD_KICK_MIN_CYC;
	localparam int FDLY = `SWD_FAULT_DLY_CYC;
	localparam int CSH = `SWD_CS_HOLD_CYC;
	localparam int MRMIN = `SWD_MR_MIN_CYC;

	// Capacitor timeout in cycles, range clamped to the valid span
	function automatic logic [TMO_W-1:0] cap_tmo(input logic [7:0] nf);
		logic [7:0] c;
		c = nf;
		if (c < `SWD_CAP_MIN_NF) begin
			c = `SWD_CAP_MIN_NF;
		end else if (c > `SWD_CAP_MAX_NF) begin
			c = `SWD_CAP_MAX_NF;
		end
		cap_tmo = TMO_W'(({24'h0, c} * `SWD_CAP_TENTHS_MS_PER_NF
			* CYC_PER_MS) / 10);
	endfunction : cap_tmo

	////////////////////////////////////////////////////////////////////
	// Kick input sampling and level-change detection
	logic kick_s1_r, kick_s2_r, kick_s3_r;
	logic kick_s1_nxt, kick_s2_nxt, kick_s3_nxt;
	logic [3:0] kick_w_r, kick_w_nxt;
	logic kick_ev;

	always_comb begin
		kick_s1_nxt = watchdog_kick_in;
		kick_s2_nxt = kick_s1_r;
		kick_s3_nxt = kick_s2_r;
		kick_w_nxt = kick_w_r;
		// Level must stand KMIN cycles; a shorter glitch counts once the restored level stands
		if (kick_s2_r != kick_s3_r) begin
			kick_w_nxt = 4'h1;
		end else if (kick_w_r != 4'h0 && kick_w_r < 4'(KMIN)) begin
			kick_w_nxt = kick_w_r + 4'h1;
		end else begin
			kick_w_nxt = 4'h0;
		end
		// A pulse counts on its qualified rising or falling part
		kick_ev = (kick_w_r == 4'(KMIN)) && (kick_s2_r == kick_s3_r);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			kick_s1_r <= 1'b0;
			kick_s2_r <= 1'b0;
			kick_s3_r <= 1'b0;
			kick_w_r <= 4'h0;
		end else begin
			kick_s1_r <= kick_s1_nxt;
			kick_s2_r <= kick_s2_nxt;
			kick_s3_r <= kick_s3_nxt;
			kick_w_r <= kick_w_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reset generation: threshold, manual reset, 200 ms timeout
	logic [CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
	logic [CNT_W-1:0] mr_cnt_r, mr_cnt_nxt;
	logic rst_act_r, rst_act_nxt;
	logic mr_hit;

	always_comb begin
		rst_cnt_nxt = rst_cnt_r;
		mr_cnt_nxt = mr_cnt_r;
		rst_act_nxt = rst_act_r;
		// Short manual presses are filtered out entirely
		if (manual_reset_in_n) begin
			mr_cnt_nxt = '0;
		end else if (mr_cnt_r < CNT_W'(MRMIN)) begin
			mr_cnt_nxt = mr_cnt_r + 1'b1;
		end
		mr_hit = (mr_cnt_r == CNT_W'(MRMIN));
		if (status_in.below_thresh || mr_hit) begin
			rst_act_nxt = 1'b1;
			rst_cnt_nxt = '0;
		end else if (rst_act_r) begin
			if (rst_cnt_r >= RST_TMO_CYC - 1'b1) begin
				rst_act_nxt = 1'b0;
			end else begin
				rst_cnt_nxt = rst_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rst_cnt_r <= '0;
			mr_cnt_r <= '0;
			rst_act_r <= 1'b1;
		end else begin
			rst_cnt_r <= rst_cnt_nxt;
			mr_cnt_r <= mr_cnt_nxt;
			rst_act_r <= rst_act_nxt;
		end
	end

	assign reset_out_n = ~rst_act_r;

	////////////////////////////////////////////////////////////////////
	// Watchdog timer
	swd_pkg::swd_wd_state_type wd_st_r, wd_st_nxt;
	logic [TMO_W-1:0] wd_cnt_r, wd_cnt_nxt;
	logic [TMO_W-1:0] tmo_cyc;
	logic wd_off;
	logic warn_n_r, warn_n_nxt;
	logic fault_n_r, fault_n_nxt;

	always_comb begin
		// Select pin high picks the internal period
		tmo_cyc = timeout_select_pin ? INT_TMO_CYC
			: cap_tmo(cap_nf_in);
		wd_off = status_in.below_thresh || status_in.batt_backup
			|| status_in.kick_open || mr_hit;
		wd_st_nxt = wd_st_r;
		wd_cnt_nxt = wd_cnt_r;
		warn_n_nxt = 1'b1;
		fault_n_nxt = fault_n_r;
		if (wd_off) begin
			wd_st_nxt = swd_pkg::SWD_WD_RUN;
			wd_cnt_nxt = '0;
			fault_n_nxt = 1'b1;
		end else begin
			case (wd_st_r)
				swd_pkg::SWD_WD_RUN: begin
					if (kick_ev) begin
						wd_cnt_nxt = '0;
					end else if (wd_cnt_r >= tmo_cyc - 1'b1) begin
						wd_cnt_nxt = '0;
						warn_n_nxt = 1'b0;
						wd_st_nxt = swd_pkg::SWD_WD_WARN;
					end else begin
						wd_cnt_nxt = wd_cnt_r + 1'b1;
					end
				end
				swd_pkg::SWD_WD_WARN, swd_pkg::SWD_WD_DLY: begin
					// Pulse runs its full width even if kicked
					warn_n_nxt = (wd_cnt_r >= TMO_W'(WARN_CYC) - 1'b1);
					wd_cnt_nxt = wd_cnt_r + 1'b1;
					if (wd_cnt_r == TMO_W'(FDLY) - 1'b1) begin
						fault_n_nxt = 1'b0;
					end
					if (kick_ev) begin
						wd_st_nxt = swd_pkg::SWD_WD_DLY;
					end
					if (warn_n_nxt) begin
						wd_cnt_nxt = '0;
						wd_st_nxt = (wd_st_r == swd_pkg::SWD_WD_DLY || kick_ev)
							? swd_pkg::SWD_WD_RUN : swd_pkg::SWD_WD_FAULT;
						if (wd_st_nxt == swd_pkg::SWD_WD_RUN) begin
							fault_n_nxt = 1'b1;
						end
					end
				end
				swd_pkg::SWD_WD_FAULT: begin
					// Period keeps running; later misses pulse again
					if (kick_ev) begin
						fault_n_nxt = 1'b1;
						wd_cnt_nxt = '0;
						wd_st_nxt = swd_pkg::SWD_WD_RUN;
					end else if (wd_cnt_r >= tmo_cyc - 1'b1) begin
						wd_cnt_nxt = '0;
						warn_n_nxt = 1'b0;
						wd_st_nxt = swd_pkg::SWD_WD_WARN;
					end else begin
						wd_cnt_nxt = wd_cnt_r + 1'b1;
					end
				end
				default: begin
					wd_st_nxt = swd_pkg::SWD_WD_RUN;
					wd_cnt_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wd_st_r <= swd_pkg::SWD_WD_RUN;
			wd_cnt_r <= '0;
			warn_n_r <= 1'b1;
			fault_n_r <= 1'b1;
		end else begin
			wd_st_r <= wd_st_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			warn_n_r <= warn_n_nxt;
			fault_n_r <= fault_n_nxt;
		end
	end

	assign wd_out.warn_n = warn_n_r;
	assign wd_out.fault_n = fault_n_r;

	////////////////////////////////////////////////////////////////////
	// Chip-select gate
	swd_pkg::swd_cs_state_type cs_st_r, cs_st_nxt;
	logic [CNT_W-1:0] cs_cnt_r, cs_cnt_nxt;

	always_comb begin
		cs_st_nxt = cs_st_r;
		cs_cnt_nxt = '0;
		case (cs_st_r)
			swd_pkg::SWD_CS_PASS: begin
				if (rst_act_nxt) begin
					// Let a running memory cycle finish
					cs_st_nxt = cs_in_n ? swd_pkg::SWD_CS_OFF
						: swd_pkg::SWD_CS_HOLD;
				end
			end
			swd_pkg::SWD_CS_HOLD: begin
				cs_cnt_nxt = cs_cnt_r + 1'b1;
				if (cs_in_n || mr_hit || cs_cnt_r >= CNT_W'(CSH) - 1'b1) begin
					cs_st_nxt = swd_pkg::SWD_CS_OFF;
				end
			end
			swd_pkg::SWD_CS_OFF: begin
				if (!rst_act_r) begin
					cs_st_nxt = swd_pkg::SWD_CS_PASS;
				end
			end
			default: cs_st_nxt = swd_pkg::SWD_CS_OFF;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cs_st_r <= swd_pkg::SWD_CS_OFF;
			cs_cnt_r <= '0;
		end else begin
			cs_st_r <= cs_st_nxt;
			cs_cnt_r <= cs_cnt_nxt;
		end
	end

	// Gate output modelled as a direct path; off means driven high
	always_comb begin
		cs_out_oe = 1'b1;
		if (cs_st_r == swd_pkg::SWD_CS_OFF) begin
			cs_out_n = 1'b1;
		end else begin
			cs_out_n = cs_in_n;
		end
	end

endmodule : swd_supervisor

// file: testbench/swd_cpu_model.sv
`timescale 1ns/10ps
module swd_cpu_model (
	input wire logic sys_clk,
	input wire logic kick_req,
	input wire logic cs_req,
	input wire logic warn_n,
	input wire logic fault_n,
	input wire logic cap_mode,
	output logic watchdog_kick_in,
	output logic cs_in_n,
	output logic timeout_select_pin,
	output logic latch_q
);
	initial watchdog_kick_in = 1'b0;
	initial latch_q = 1'b1;
	// Strapped to supply or capacitor, never floated or grounded
	assign timeout_select_pin = ~cap_mode;
	assign cs_in_n = ~cs_req;
	always @(negedge sys_clk) begin
		watchdog_kick_in <= watchdog_kick_in ^ kick_req;
	end
	// Two misses in a row clock a low fault in
	always @(negedge warn_n) begin
		latch_q <= fault_n;
	end
endmodule : swd_cpu_model

// file: testbench/swd_supervisor_props.sv
`timescale 1ns/10ps
module swd_sup_props #(
	parameter logic [23:0] WARN_CYC = 24'h004E20
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic watchdog_kick_in,
	input wire swd_pkg::swd_status_type status_in,
	input wire logic reset_out_n,
	input wire swd_pkg::swd_wd_out_type wd_out,
	input wire logic cs_in_n,
	input wire logic cs_out_n,
	input wire logic cs_out_oe
);
	logic [15:0] lo_r, lo_nxt, wl_r, wl_nxt;
	logic [7:0] sk_r, sk_nxt;
	logic kd_r, kd_nxt, st;
	assign st = |status_in;
	////////////////////
	always_comb begin
		lo_nxt = reset_out_n ? 16'h0000 : lo_r + {15'h0000, lo_r != 16'hFFFF};
		wl_nxt = wd_out.warn_n ? 16'h0000 : wl_r + 16'h0001;
		kd_nxt = watchdog_kick_in;
		sk_nxt = (watchdog_kick_in != kd_r) ? 8'h00 : sk_r + {7'h00, sk_r != 8'hFF};
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lo_r <= 16'h0000;
			wl_r <= 16'h0000;
			sk_r <= 8'hFF;
			kd_r <= watchdog_kick_in;
		end else begin
			lo_r <= lo_nxt;
			wl_r <= wl_nxt;
			sk_r <= sk_nxt;
			kd_r <= kd_nxt;
		end
	end
	////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	cs_drive_a: assert property (cs_out_oe)
		else $error("chip select not driven");
	cs_pass_a: assert property (reset_out_n && $past(reset_out_n)
		|-> cs_out_n == cs_in_n) else $error("chip select not passed");
	cs_block_a: assert property (!reset_out_n && cs_in_n |=> cs_out_n
		|| reset_out_n) else $error("chip select leaked");
	cs_hold_limit_a: assert property (lo_r > 16'h012E |-> cs_out_n)
		else $error("chip select held too long");
	fault_off_a: assert property (st && $past(st) |-> wd_out.fault_n)
		else $error("fault while disabled");
	fault_lag_a: assert property ($fell(wd_out.warn_n) && wd_out.fault_n
		|-> wd_out.fault_n ##1 wd_out.fault_n ##1 !wd_out.fault_n)
		else $error("fault lag wrong");
	warn_len_a: assert property ($rose(wd_out.warn_n) && reset_out_n
		&& !$past(st) |-> wl_r == WARN_CYC[15:0]) else $error("warn width");
	fault_hold_a: assert property ($rose(wd_out.fault_n)
		|-> st || !reset_out_n || sk_r < 8'h0C) else $error("fault released");
	cover property ($fell(wd_out.warn_n));
	cover property ($rose(wd_out.fault_n));
	cover property ($rose(reset_out_n));
endmodule : swd_sup_props
bind swd_supervisor swd_sup_props #(.WARN_CYC(WARN_CYC)) chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .watchdog_kick_in(watchdog_kick_in),
	.status_in(status_in), .reset_out_n(reset_out_n), .wd_out(wd_out),
	.cs_in_n(cs_in_n), .cs_out_n(cs_out_n), .cs_out_oe(cs_out_oe));

// file: testbench/swd_supervisor_bench.sv
`timescale 1ns/10ps
module swd_supervisor_bench;
	localparam int TMO = 32'h000000C8;
	localparam int WARN = 32'h00000014;
	localparam int RTMO = 32'h00000064;
	// 2.1 ms per nF, 5 nF, 10 cycles per ms
	localparam int CAP = 5 * 21 * 10 / 10;
	logic cap_mode = 1'b0;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic kick_req = 1'b0;
	logic cs_req = 1'b0;
	logic mr_n = 1'b1;
	swd_pkg::swd_status_type st = 3'h0;
	logic kick, sel, q, cs_in_n, rst_n, cs_n, cs_oe;
	swd_pkg::swd_wd_out_type wd;
	int bad_count = 0;
	int n_checks = 0;
	swd_supervisor #(.INT_TMO_CYC(32'(TMO)), .WARN_CYC(24'(WARN)),
		.RST_TMO_CYC(24'(RTMO)), .CYC_PER_MS(24'h00000A)) uut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .watchdog_kick_in(kick),
		.status_in(st), .timeout_select_pin(sel), .cap_nf_in(8'h05),
		.manual_reset_in_n(mr_n), .cs_in_n(cs_in_n), .reset_out_n(rst_n),
		.wd_out(wd), .cs_out_n(cs_n), .cs_out_oe(cs_oe));
	swd_cpu_model cpu (.sys_clk(sys_clk), .kick_req(kick_req),
		.cs_req(cs_req), .warn_n(wd.warn_n), .fault_n(wd.fault_n),
		.cap_mode(cap_mode),
		.watchdog_kick_in(kick), .cs_in_n(cs_in_n),
		.timeout_select_pin(sel), .latch_q(q));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task automatic cmp_bit(input logic a, input logic e);
		n_checks++;
		if (a !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %b want %b", $time, a, e);
		end
	endtask : cmp_bit
	task automatic cmp_span(input int a, input int lo, input int hi);
		n_checks++;
		if (a < lo || a > hi) begin
			bad_count++;
			$display("mismatch at %0t: span %0d", $time, a);
		end
	endtask : cmp_span
	function automatic logic pick(input int w);
		return w == 0 ? rst_n : (w == 1 ? wd.warn_n : wd.fault_n);
	endfunction : pick
	// Bounded wait; the count doubles as the measured delay
	task automatic wait_lvl(input int w, input logic v, output int n);
		n = 0;
		while (pick(w) !== v && n < 1000) begin
			cyc(1);
			n++;
		end
	endtask : wait_lvl
	task automatic kick_once;
		kick_req <= 1'b1;
		cyc(1);
		kick_req <= 1'b0;
		cyc(1);
	endtask : kick_once
	////////////////////
	task automatic t_reset;
		int n;
		cmp_bit(rst_n, 1'b0);
		cmp_bit(cs_n, 1'b1);
		cmp_bit(wd.fault_n, 1'b1);
		wait_lvl(0, 1'b1, n);
		cmp_span(n, RTMO - 3, RTMO + 3);
		$display("test reset done");
	endtask : t_reset
	// Mode 0: brownout, hold limit; 1: manual reset; 2: early release
	task automatic t_pdown(input int mode);
		int n;
		cs_req <= 1'b1;
		cyc(2);
		cmp_bit(cs_n, 1'b0);
		st.below_thresh <= (mode != 1);
		mr_n <= (mode != 1);
		wait_lvl(0, 1'b0, n);
		cyc(mode == 0 ? 250 : 20);
		cmp_bit(cs_n, logic'(mode == 1));
		cs_req <= (mode == 0);
		cyc(mode == 0 ? 60 : 3);
		cmp_bit(cs_n, 1'b1);
		cs_req <= 1'b1;
		cyc(3);
		cmp_bit(cs_n, 1'b1);
		cmp_bit(wd.fault_n, 1'b1);
		cmp_bit(wd.warn_n, 1'b1);
		st.below_thresh <= 1'b0;
		mr_n <= 1'b1;
		cyc(1);
		cmp_bit(cs_n, 1'b1);
		wait_lvl(0, 1'b1, n);
		cmp_span(n, RTMO - 3, RTMO + 3);
		cyc(1);
		cmp_bit(cs_n, 1'b0);
		cs_req <= 1'b0;
		cyc(2);
		cmp_bit(cs_n, 1'b1);
		$display("test power down %0d done", mode);
	endtask : t_pdown
	task automatic t_wd;
		int n;
		for (int i = 0; i < 4; i++) begin
			kick_once;
			cyc(120);
			cmp_bit(wd.warn_n, 1'b1);
		end
		kick_once;
		kick_once;
		wait_lvl(1, 1'b0, n);
		cmp_span(n, TMO - 6, TMO + 8);
		cmp_bit(wd.fault_n, 1'b1);
		cyc(3);
		cmp_bit(wd.fault_n, 1'b0);
		cmp_bit(q, 1'b1);
		wait_lvl(1, 1'b1, n);
		cmp_span(n, WARN - 5, WARN - 1);
		wait_lvl(1, 1'b0, n);
		cyc(2);
		cmp_bit(wd.fault_n, 1'b0);
		cmp_bit(q, 1'b0);
		wait_lvl(1, 1'b1, n);
		kick_once;
		cyc(8);
		cmp_bit(wd.fault_n, 1'b1);
		$display("test watchdog done");
	endtask : t_wd
	task automatic t_cap;
		int n;
		cap_mode <= 1'b1;
		kick_once;
		wait_lvl(1, 1'b0, n);
		cmp_span(n, CAP - 6, CAP + 8);
		wait_lvl(1, 1'b1, n);
		kick_once;
		cyc(8);
		cmp_bit(wd.fault_n, 1'b1);
		cap_mode <= 1'b0;
		$display("test capacitor timeout done");
	endtask : t_cap
	// Each disabling status in turn, kicks offered meanwhile
	task automatic t_status;
		int n;
		for (int b = 0; b < 3; b++) begin
			kick_once;
			st <= swd_pkg::swd_status_type'(3'h4 >> b);
			n = 0;
			for (int k = 0; k < 450; k++) begin
				kick_req <= (k % 150 == 0);
				cyc(1);
				if (wd.warn_n !== 1'b1) n++;
			end
			cmp_span(n, 0, 0);
			cmp_bit(wd.fault_n, 1'b1);
			st <= 3'h0;
			cyc(1);
			wait_lvl(0, 1'b1, n);
		end
		$display("test status done");
	endtask : t_status
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	////////////////////
	initial begin
		#1000000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		cyc(5);
		sys_rst <= 1'b0;
		t_reset;
		t_pdown(0);
		t_pdown(1);
		t_pdown(2);
		t_wd;
		t_cap;
		t_status;
		report_and_stop;
	end
endmodule : swd_supervisor_bench
